//--- src/epds_sequencer.sv
`timescale 1ns/1ns
`default_nettype none


module epds_sequencer
  import epds_pkg::*;
#(
  parameter int unsigned STEP_SHORT_CYCLES = EPDS_STEP_SHORT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_pin_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic linear_reg_a_en_o,
  output logic linear_reg_b_en_o,
  output logic aux_output_a_out_o,
  output logic aux_output_a_oe_o,
  output logic aux_output_b_out_o,
  output logic aux_output_b_oe_o,
  output logic clock_input_pin_sel_o
);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Pin drive as {out, oe}; an open-drain pin only ever pulls low.
  function automatic logic [1:0] pin_drive(input logic val,
                                           input logic drain);
    logic [1:0] res;
    res = drain ? {1'b0, !val} : {val, 1'b1};
    return res;
  endfunction

  function automatic logic [3:0] on_field(input logic [7:0] r);
    logic [3:0] f;
    f = r[EPDS_ON_LSB +: 4];
    return f;
  endfunction

  function automatic logic [3:0] off_field(input logic [7:0] r);
    logic [3:0] f;
    f = r[EPDS_OFF_LSB +: 4];
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [7:0] lra_dly_reg, lra_dly_next;
  logic [7:0] lrb_dly_reg, lrb_dly_next;
  logic [7:0] axa_dly_reg, axa_dly_next;
  logic [7:0] axb_dly_reg, axb_dly_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    lra_dly_next = lra_dly_reg;
    lrb_dly_next = lrb_dly_reg;
    axa_dly_next = axa_dly_reg;
    axb_dly_next = axb_dly_reg;
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    if (reg_wr_i) begin
      if (reg_addr_i == EPDS_ADDR_LREG_A_DLY) begin
        lra_dly_next = reg_wdata_i;
      end else if (reg_addr_i == EPDS_ADDR_LREG_B_DLY) begin
        lrb_dly_next = reg_wdata_i;
      end else if (reg_addr_i == EPDS_ADDR_AUX_A_DLY) begin
        axa_dly_next = reg_wdata_i;
      end else if (reg_addr_i == EPDS_ADDR_AUX_B_DLY) begin
        axb_dly_next = reg_wdata_i;
      end else if (reg_addr_i == EPDS_ADDR_AUX_CTRL) begin
        // Bits 7 and 3 are read-only zero.
        ctrl_next = reg_wdata_i & EPDS_AUX_CTRL_WMASK;
      end else if (reg_addr_i == EPDS_ADDR_CONFIG) begin
        cfg_next = reg_wdata_i;
      end
    end
  end

  // Read data is registered; a write in the same cycle is not yet seen.
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_i) begin
      if (reg_addr_i == EPDS_ADDR_LREG_A_DLY) begin
        rdata_next = lra_dly_reg;
      end else if (reg_addr_i == EPDS_ADDR_LREG_B_DLY) begin
        rdata_next = lrb_dly_reg;
      end else if (reg_addr_i == EPDS_ADDR_AUX_A_DLY) begin
        rdata_next = axa_dly_reg;
      end else if (reg_addr_i == EPDS_ADDR_AUX_B_DLY) begin
        rdata_next = axb_dly_reg;
      end else if (reg_addr_i == EPDS_ADDR_AUX_CTRL) begin
        rdata_next = ctrl_reg;
      end else if (reg_addr_i == EPDS_ADDR_CONFIG) begin
        rdata_next = cfg_reg;
      end else begin
        rdata_next = EPDS_RDATA_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lra_dly_reg <= EPDS_DLY_RST;
      lrb_dly_reg <= EPDS_DLY_RST;
      axa_dly_reg <= EPDS_DLY_RST;
      axb_dly_reg <= EPDS_DLY_RST;
      ctrl_reg <= EPDS_AUX_CTRL_RST;
      cfg_reg <= EPDS_CONFIG_RST;
      rdata_reg <= EPDS_RDATA_UNMAPPED;
    end else begin
      lra_dly_reg <= lra_dly_next;
      lrb_dly_reg <= lrb_dly_next;
      axa_dly_reg <= axa_dly_next;
      axb_dly_reg <= axb_dly_next;
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign clock_input_pin_sel_o = cfg_reg[EPDS_PIN_FN_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Enable pin edge detection.

  logic en_prev_reg, en_prev_next;
  logic rise_w, fall_w;
  logic up_sel_w, dn_sel_w;

  // The pin is taken as synchronous; an enable held high through reset
  // is seen as a rising edge on the first cycle after release.
  assign en_prev_next = en_pin_i;
  assign rise_w = en_pin_i && !en_prev_reg;
  assign fall_w = !en_pin_i && en_prev_reg;
  assign up_sel_w = cfg_reg[EPDS_UP_SEL_BIT];
  assign dn_sel_w = cfg_reg[EPDS_DN_SEL_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_prev_reg <= 1'b0;
    end else begin
      en_prev_reg <= en_prev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Four delay channels.

  logic lra_state_w, lrb_state_w, axa_state_w, axb_state_w;

  epds_delay_chan #(.STEP_CYC(STEP_SHORT_CYCLES)) u_lreg_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rise_i(rise_w),
    .fall_i(fall_w),
    .on_code_i(on_field(lra_dly_reg)),
    .off_code_i(off_field(lra_dly_reg)),
    .up_sel_i(up_sel_w),
    .dn_sel_i(dn_sel_w),
    .state_o(lra_state_w)
  );

  epds_delay_chan #(.STEP_CYC(STEP_SHORT_CYCLES)) u_lreg_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rise_i(rise_w),
    .fall_i(fall_w),
    .on_code_i(on_field(lrb_dly_reg)),
    .off_code_i(off_field(lrb_dly_reg)),
    .up_sel_i(up_sel_w),
    .dn_sel_i(dn_sel_w),
    .state_o(lrb_state_w)
  );

  epds_delay_chan #(.STEP_CYC(STEP_SHORT_CYCLES)) u_aux_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rise_i(rise_w),
    .fall_i(fall_w),
    .on_code_i(on_field(axa_dly_reg)),
    .off_code_i(off_field(axa_dly_reg)),
    .up_sel_i(up_sel_w),
    .dn_sel_i(dn_sel_w),
    .state_o(axa_state_w)
  );

  epds_delay_chan #(.STEP_CYC(STEP_SHORT_CYCLES)) u_aux_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rise_i(rise_w),
    .fall_i(fall_w),
    .on_code_i(on_field(axb_dly_reg)),
    .off_code_i(off_field(axb_dly_reg)),
    .up_sel_i(up_sel_w),
    .dn_sel_i(dn_sel_w),
    .state_o(axb_state_w)
  );

  assign linear_reg_a_en_o = lra_state_w;
  assign linear_reg_b_en_o = lrb_state_w;

  ////////////////////////////////////////////////////////////////////////
  // Auxiliary output pins.

  logic axa_val_w, axb_val_w;
  logic [1:0] axa_pin_reg, axa_pin_next;
  logic [1:0] axb_pin_reg, axb_pin_next;

  // Without gating the level bit alone drives the pin, so software can
  // use it as a plain output whatever the enable pin does.
  assign axa_val_w = ctrl_reg[EPDS_AUX_A_GATE_BIT]
    ? (ctrl_reg[EPDS_AUX_A_LEVEL_BIT] && axa_state_w)
    : ctrl_reg[EPDS_AUX_A_LEVEL_BIT];
  assign axb_val_w = ctrl_reg[EPDS_AUX_B_GATE_BIT]
    ? (ctrl_reg[EPDS_AUX_B_LEVEL_BIT] && axb_state_w)
    : ctrl_reg[EPDS_AUX_B_LEVEL_BIT];

  always_comb begin
    axa_pin_next = pin_drive(axa_val_w,
                             ctrl_reg[EPDS_AUX_A_DRAIN_BIT]);
    if (cfg_reg[EPDS_PIN_FN_BIT]) begin
      // The pin belongs to the clock input; leave it undriven.
      axb_pin_next = 2'h0;
    end else begin
      axb_pin_next = pin_drive(axb_val_w,
                               ctrl_reg[EPDS_AUX_B_DRAIN_BIT]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      axa_pin_reg <= 2'h0;
      axb_pin_reg <= 2'h0;
    end else begin
      axa_pin_reg <= axa_pin_next;
      axb_pin_reg <= axb_pin_next;
    end
  end

  assign aux_output_a_out_o = axa_pin_reg[1];
  assign aux_output_a_oe_o = axa_pin_reg[0];
  assign aux_output_b_out_o = axb_pin_reg[1];
  assign aux_output_b_oe_o = axb_pin_reg[0];

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  a_lra_zero_on: assert property (@(posedge clk_i) disable iff (rst_i)
    (rise_w && on_field(lra_dly_reg) == EPDS_CODE_ZERO) |=>
    linear_reg_a_en_o)
    else $error("first regulator not on right after zero-delay rise");

  a_lra_zero_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (fall_w && off_field(lra_dly_reg) == EPDS_CODE_ZERO) |=>
    !linear_reg_a_en_o)
    else $error("first regulator not off right after zero-delay fall");

  a_lrb_on_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    (rise_w && on_field(lrb_dly_reg) != EPDS_CODE_ZERO &&
     !linear_reg_b_en_o && en_pin_i) |=> !linear_reg_b_en_o [*2])
    else $error("second regulator turned on before its delay");

  a_lrb_off_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    (fall_w && off_field(lrb_dly_reg) != EPDS_CODE_ZERO &&
     linear_reg_b_en_o) |=> linear_reg_b_en_o)
    else $error("second regulator turned off before its delay");

  a_aux_a_push: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_reg[EPDS_AUX_A_DRAIN_BIT] |=> aux_output_a_oe_o)
    else $error("push-pull output A not driven");

  a_aux_a_drain: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[EPDS_AUX_A_DRAIN_BIT] |=> !aux_output_a_out_o)
    else $error("open-drain output A driven high");

  a_aux_a_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl_reg[EPDS_AUX_A_GATE_BIT] && !ctrl_reg[EPDS_AUX_A_DRAIN_BIT])
    |=> aux_output_a_out_o == $past(ctrl_reg[EPDS_AUX_A_LEVEL_BIT]))
    else $error("output A does not follow its level bit");

  a_aux_a_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_reg[EPDS_AUX_A_GATE_BIT] && !axa_state_w &&
     !ctrl_reg[EPDS_AUX_A_DRAIN_BIT]) |=> !aux_output_a_out_o)
    else $error("gated output A high while delayed enable low");

  a_aux_b_clock: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_reg[EPDS_PIN_FN_BIT] |=> !aux_output_b_oe_o)
    else $error("shared pin driven while used as clock input");

  a_aux_b_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cfg_reg[EPDS_PIN_FN_BIT] && ctrl_reg[EPDS_AUX_B_GATE_BIT] &&
     !(ctrl_reg[EPDS_AUX_B_LEVEL_BIT] && axb_state_w)) |=>
    aux_output_b_oe_o && !aux_output_b_out_o)
    else $error("gated output B not driven low");

  a_aux_b_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cfg_reg[EPDS_PIN_FN_BIT] && !ctrl_reg[EPDS_AUX_B_GATE_BIT] &&
     !ctrl_reg[EPDS_AUX_B_DRAIN_BIT] && ctrl_reg[EPDS_AUX_B_LEVEL_BIT])
    |=> aux_output_b_oe_o && aux_output_b_out_o)
    else $error("output B not high with level bit set");

  c_lra_delayed_on: cover property (@(posedge clk_i) disable iff (rst_i)
    rise_w && on_field(lra_dly_reg) != EPDS_CODE_ZERO ##1
    !linear_reg_a_en_o);

  c_cancel_rise: cover property (@(posedge clk_i) disable iff (rst_i)
    rise_w ##1 fall_w);

  c_aux_b_gated: cover property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[EPDS_AUX_B_GATE_BIT] && !cfg_reg[EPDS_PIN_FN_BIT] &&
    axb_state_w);

endmodule

`default_nettype wire

//--- src/epds_pkg.sv
package epds_pkg;

  // Register offsets on the internal register port.
  localparam logic [7:0] EPDS_ADDR_LREG_A_DLY = 8'h0E;
  localparam logic [7:0] EPDS_ADDR_LREG_B_DLY = 8'h0F;
  localparam logic [7:0] EPDS_ADDR_AUX_A_DLY = 8'h10;
  localparam logic [7:0] EPDS_ADDR_AUX_B_DLY = 8'h11;
  localparam logic [7:0] EPDS_ADDR_AUX_CTRL = 8'h12;
  localparam logic [7:0] EPDS_ADDR_CONFIG = 8'h13;
  localparam logic [7:0] EPDS_RDATA_UNMAPPED = 8'h00;

  // Delay register fields: on delay in the low nibble, off in the high.
  localparam int unsigned EPDS_ON_LSB = 0;
  localparam int unsigned EPDS_OFF_LSB = 4;

  // Output control register fields.
  localparam int unsigned EPDS_AUX_A_LEVEL_BIT = 0;
  localparam int unsigned EPDS_AUX_A_GATE_BIT = 1;
  localparam int unsigned EPDS_AUX_A_DRAIN_BIT = 2;
  localparam int unsigned EPDS_AUX_B_LEVEL_BIT = 4;
  localparam int unsigned EPDS_AUX_B_GATE_BIT = 5;
  localparam int unsigned EPDS_AUX_B_DRAIN_BIT = 6;
  localparam logic [7:0] EPDS_AUX_CTRL_WMASK = 8'h77;

  // Configuration register fields used by this block.
  localparam int unsigned EPDS_UP_SEL_BIT = 6;
  localparam int unsigned EPDS_DN_SEL_BIT = 5;
  localparam int unsigned EPDS_PIN_FN_BIT = 4;

  // Reset values.
  localparam logic [7:0] EPDS_DLY_RST = 8'h00;
  localparam logic [7:0] EPDS_AUX_CTRL_RST = 8'h44;
  localparam logic [7:0] EPDS_CONFIG_RST = 8'h1F;
  localparam logic [3:0] EPDS_CODE_ZERO = 4'h0;

  // Timing: one short delay step and the clock period.
  localparam int unsigned EPDS_STEP_SHORT_US = 500;
  localparam int unsigned EPDS_CLK_PERIOD_NS = 100;
  localparam int unsigned EPDS_STEP_SHORT_CYC =
    (EPDS_STEP_SHORT_US * 1000 + EPDS_CLK_PERIOD_NS - 1) /
    EPDS_CLK_PERIOD_NS;
  localparam int unsigned EPDS_LONG_STEP_MULT = 2;

  typedef enum logic {
    EPDS_CH_IDLE = 1'b0,
    EPDS_CH_WAIT = 1'b1
  } epds_chan_e;

endpackage

//--- src/epds_delay_chan.sv
`timescale 1ns/1ns
`default_nettype none

module epds_delay_chan
  import epds_pkg::*;
#(
  parameter int unsigned STEP_CYC = EPDS_STEP_SHORT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rise_i,
  input wire logic fall_i,
  input wire logic [3:0] on_code_i,
  input wire logic [3:0] off_code_i,
  input wire logic up_sel_i,
  input wire logic dn_sel_i,
  output logic state_o
);

  epds_chan_e st_reg, st_next;
  logic state_reg, state_next;
  logic tgt_reg, tgt_next;
  logic long_reg, long_next;
  logic [3:0] steps_reg, steps_next;
  logic [19:0] pre_reg, pre_next;
  logic [19:0] last_w;

  // The step length is latched at the edge so that a range change in
  // the middle of a delay cannot stretch or shorten that delay.
  assign last_w = long_reg ? 20'(EPDS_LONG_STEP_MULT * STEP_CYC - 1)
                           : 20'(STEP_CYC - 1);
  assign state_o = state_reg;

  always_comb begin
    st_next = st_reg;
    state_next = state_reg;
    tgt_next = tgt_reg;
    long_next = long_reg;
    steps_next = steps_reg;
    pre_next = pre_reg;
    if (rise_i || fall_i) begin
      // A new edge replaces any pending delay.
      tgt_next = rise_i;
      long_next = rise_i ? up_sel_i : dn_sel_i;
      steps_next = rise_i ? on_code_i : off_code_i;
      pre_next = '0;
      if ((rise_i ? on_code_i : off_code_i) == EPDS_CODE_ZERO) begin
        state_next = rise_i;
        st_next = EPDS_CH_IDLE;
      end else begin
        st_next = EPDS_CH_WAIT;
      end
    end else begin
      case (st_reg)
        EPDS_CH_WAIT: begin
          if (pre_reg == last_w) begin
            pre_next = '0;
            if (steps_reg == 4'h1) begin
              state_next = tgt_reg;
              st_next = EPDS_CH_IDLE;
            end else begin
              steps_next = steps_reg - 4'h1;
            end
          end else begin
            pre_next = pre_reg + 20'h00001;
          end
        end
        default: begin
          st_next = EPDS_CH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= EPDS_CH_IDLE;
      state_reg <= 1'b0;
      tgt_reg <= 1'b0;
      long_reg <= 1'b0;
      steps_reg <= 4'h0;
      pre_reg <= 20'h00000;
    end else begin
      st_reg <= st_next;
      state_reg <= state_next;
      tgt_reg <= tgt_next;
      long_reg <= long_next;
      steps_reg <= steps_next;
      pre_reg <= pre_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on delay length and cancellation.

  logic [23:0] elapsed_reg;
  logic [3:0] code_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      elapsed_reg <= 24'h000000;
      code_reg <= 4'h0;
    end else if (rise_i || fall_i) begin
      elapsed_reg <= 24'h000001;
      code_reg <= rise_i ? on_code_i : off_code_i;
    end else if (elapsed_reg != 24'hFFFFFF) begin
      elapsed_reg <= elapsed_reg + 24'h000001;
    end
  end

  a_delay_exact: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == EPDS_CH_WAIT && pre_reg == last_w && steps_reg == 4'h1 &&
     !rise_i && !fall_i) |->
    elapsed_reg == 24'(code_reg) * 24'({4'h0, last_w} + 24'h000001))
    else $error("delay length differs from code times step");

  a_cancel_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == EPDS_CH_WAIT && tgt_reg && fall_i && !state_reg) |=>
    !state_reg)
    else $error("cancelled rising delay still turned the output on");

  a_state_only_end: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == EPDS_CH_WAIT && pre_reg != last_w && !rise_i && !fall_i)
    |=> $stable(state_reg))
    else $error("output moved before its delay ran out");

  c_long_step: cover property (@(posedge clk_i) disable iff (rst_i)
    st_reg == EPDS_CH_WAIT && long_reg ##1 st_reg == EPDS_CH_IDLE);

endmodule

`default_nettype wire

//--- tb/epds_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Host side of the block: drives the enable pin and the register port.
module epds_host_model (
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic en_pin_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);

  initial begin
    en_pin_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  ////////////////////////////////////////
  // Released lines are inverted so that a block sampling them outside a
  // strobe sees a changed value instead of a lucky stale one.
  task automatic release_bus();
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    reg_addr_o = addr;
    reg_wdata_o = data;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    release_bus();
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_i);
    reg_addr_o = addr;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    data = reg_rdata_i;
    release_bus();
  endtask

  task automatic set_en(input logic level);
    @(negedge clk_i);
    en_pin_o = level;
  endtask

endmodule

`default_nettype wire

//--- tb/tb_enable_pin_delay_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

module tb_enable_pin_delay_sequencer
  import epds_pkg::*;
;

  // A short step keeps the longest delay near 120 cycles.
  localparam int unsigned S = 4;

  logic clk_i;
  logic rst_i;
  logic en_pin, reg_wr, reg_rd, lreg_a, lreg_b, clk_sel;
  logic a_out, a_oe, b_out, b_oe, pin_a, pin_b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int n_fail = 0;
  int n_compared = 0;

  // Output A is open-drain capable and pulled up; the shared pin is pulled
  // down.
  assign pin_a = a_oe ? a_out : 1'b1;
  assign pin_b = b_oe ? b_out : 1'b0;

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  epds_host_model epds_host_model_inst (
    .clk_i(clk_i), .reg_rdata_i(reg_rdata), .en_pin_o(en_pin),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));

  epds_sequencer #(.STEP_SHORT_CYCLES(S)) epds_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .en_pin_i(en_pin),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .linear_reg_a_en_o(lreg_a), .linear_reg_b_en_o(lreg_b),
    .aux_output_a_out_o(a_out), .aux_output_a_oe_o(a_oe),
    .aux_output_b_out_o(b_out), .aux_output_b_oe_o(b_oe),
    .clock_input_pin_sel_o(clk_sel));

  ////////////////////////////////////////
  task automatic conclude();
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    epds_host_model_inst.read_reg(addr, d);
    check(d, exp);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    epds_host_model_inst.write_reg(addr, data);
  endtask

  ////////////////////////////////////////
  task automatic reset_values();
    @(negedge clk_i);
    check({2'h0, lreg_a, lreg_b, b_oe, clk_sel, a_oe, a_out}, 8'h06);
    check(reg_rdata, 8'h00);
    rd_check(EPDS_ADDR_LREG_A_DLY, 8'h00);
    rd_check(EPDS_ADDR_LREG_B_DLY, 8'h00);
    rd_check(EPDS_ADDR_AUX_A_DLY, 8'h00);
    rd_check(EPDS_ADDR_AUX_B_DLY, 8'h00);
    rd_check(EPDS_ADDR_AUX_CTRL, 8'h44);
    rd_check(EPDS_ADDR_CONFIG, 8'h1F);
  endtask

  // Bits 7 and 3 of the output control register are read-only zero.
  task automatic reg_access();
    logic [7:0] a;
    for (int i = 0; i < 6; i++) begin
      a = EPDS_ADDR_LREG_A_DLY + 8'(i);
      wr(a, 8'hA5);
      rd_check(a, (a == EPDS_ADDR_AUX_CTRL) ? 8'h25 : 8'hA5);
    end
    wr(8'h20, 8'hFF);
    rd_check(8'h20, 8'h00);
  endtask

  // Each channel is timed from the edge to its first cycle at the new level.
  task automatic run_edge(input logic level, input logic [7:0] cfg,
                          input logic long_step, input logic [15:0] codes);
    int exp_k[4];
    int got_k[4];
    logic [3:0] now;
    wr(EPDS_ADDR_CONFIG, cfg);
    for (int i = 0; i < 4; i++) begin
      got_k[i] = -1;
      exp_k[i] = codes[15-4*i -: 4] * S * (long_step ? 2 : 1) + (i / 2);
    end
    epds_host_model_inst.set_en(level);
    for (int k = 0; k < 200; k++) begin
      @(negedge clk_i);
      now = {lreg_a, lreg_b, pin_a, pin_b};
      for (int i = 0; i < 4; i++) begin
        if (got_k[i] < 0 && now[3-i] === level) got_k[i] = k;
      end
    end
    for (int i = 0; i < 4; i++) begin
      check(8'(got_k[i]), 8'(exp_k[i]));
      if (got_k[i] < 0) conclude();
    end
  endtask

  task automatic seq_delays();
    wr(EPDS_ADDR_LREG_A_DLY, 8'h02);
    wr(EPDS_ADDR_LREG_B_DLY, 8'h3F);
    wr(EPDS_ADDR_AUX_A_DLY, 8'hF1);
    wr(EPDS_ADDR_AUX_B_DLY, 8'h50);
    wr(EPDS_ADDR_AUX_CTRL, 8'h33);
    run_edge(1'b1, 8'h00, 1'b0, 16'h2F10);
    run_edge(1'b0, 8'h20, 1'b1, 16'h03F5);
    run_edge(1'b1, 8'h40, 1'b1, 16'h2F10);
    run_edge(1'b0, 8'h00, 1'b0, 16'h03F5);
  endtask

  // The enable pin is low and every channel has settled low here.
  task automatic static_control();
    logic v;
    logic [1:0] e;
    wr(EPDS_ADDR_CONFIG, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(EPDS_ADDR_AUX_CTRL, {1'b0, 3'(c), 1'b0, 3'(c)});
      v = c[1] ? 1'b0 : c[0];
      e = c[2] ? {1'b0, !v} : {v, 1'b1};
      repeat (2) @(negedge clk_i);
      check({4'h0, a_out, a_oe, b_out, b_oe}, {4'h0, e, e});
    end
    wr(EPDS_ADDR_CONFIG, 8'h10);
    repeat (2) @(negedge clk_i);
    check({6'h0, b_oe, clk_sel}, 8'h01);
  endtask

  // A fall inside a pending rise delay must leave the regulators off.
  task automatic cancel_pending();
    logic seen;
    seen = 1'b0;
    wr(EPDS_ADDR_LREG_A_DLY, 8'h04);
    epds_host_model_inst.set_en(1'b1);
    repeat (3) @(negedge clk_i);
    epds_host_model_inst.set_en(1'b0);
    for (int k = 0; k < 40; k++) begin
      @(negedge clk_i);
      seen = seen | lreg_a | lreg_b;
    end
    check({7'h0, seen}, 8'h00);
  endtask

  ////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    reset_values();
    reg_access();
    seq_delays();
    static_control();
    cancel_pending();
    conclude();
  end

endmodule

`default_nettype wire
